// File: logic/ptpc_pkg.sv
// package: register map, field layout, frame event and capture types
package ptpc_pkg;
  localparam int unsigned AXI_AW = 12;
  localparam logic [11:0] AUX_HI_OFS   = 12'h18c;
  localparam logic [11:0] AUX_LO_OFS   = 12'h190;
  localparam logic [11:0] CFG_OFS      = 12'h194;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h1a0;
  localparam logic [11:0] IRQ_CLR_OFS  = 12'h1a4;
  localparam logic [11:0] IRQ_EN_OFS   = 12'h1a8;

  localparam int unsigned P2_ROLE_BIT  = 31;
  localparam int unsigned P2_PRI_BIT   = 30;
  localparam int unsigned P2_ALT1_BIT  = 29;
  localparam int unsigned P2_ALT2_BIT  = 28;
  localparam int unsigned P2_ALT3_BIT  = 27;
  localparam int unsigned P2_USER_BIT  = 26;
  localparam int unsigned P2_LKRX_BIT  = 25;
  localparam int unsigned P2_LKTX_BIT  = 24;
  localparam int unsigned P1_ROLE_BIT  = 23;
  localparam int unsigned P1_PRI_BIT   = 22;
  localparam int unsigned P1_ALT1_BIT  = 21;
  localparam int unsigned P1_ALT2_BIT  = 20;

  localparam logic [31:0] CFG_MASK     = 32'hfff0_0000;
  localparam logic [31:0] CFG_RESET    = 32'h4340_0000;
  localparam logic [15:0] AUX_HI_RESET = 16'h0000;
  localparam logic [31:0] AUX_LO_RESET = 32'h0000_0000;
  localparam logic [3:0]  IRQ_EN_RESET = 4'h0;

  localparam logic [47:0] PRI_ADDR  = 48'h0100_5e00_0181;
  localparam logic [47:0] ALT1_ADDR = 48'h0100_5e00_0182;
  localparam logic [47:0] ALT2_ADDR = 48'h0100_5e00_0183;
  localparam logic [47:0] ALT3_ADDR = 48'h0100_5e00_0184;

  // capture flag / status bit order
  localparam int unsigned FL_P1_RX = 0;
  localparam int unsigned FL_P1_TX = 1;
  localparam int unsigned FL_P2_RX = 2;
  localparam int unsigned FL_P2_TX = 3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic        valid;
    logic        is_tx;
    logic        is_sync;
    logic        is_dreq;
    logic [47:0] dst;
    logic [47:0] uuid;
    logic [15:0] seq;
  } ptpc_evt_t;

  typedef struct packed {
    logic [63:0] clock;
    logic [47:0] uuid;
    logic [15:0] seq;
  } ptpc_cap_t;

  typedef struct packed {
    logic pri;
    logic alt1;
    logic alt2;
    logic alt3;
    logic user;
  } ptpc_addr_en_t;

  // master: tx sync / rx delay_req; slave: tx delay_req / rx sync
  function automatic logic capture_wanted(input logic master, input ptpc_evt_t e);
    if (master) begin
      capture_wanted = (e.is_tx && e.is_sync) || (!e.is_tx && e.is_dreq);
    end else begin
      capture_wanted = (e.is_tx && e.is_dreq) || (!e.is_tx && e.is_sync);
    end
  endfunction : capture_wanted

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      apply_strb[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
  endfunction : apply_strb
endpackage : ptpc_pkg

// File: logic/ptpc_addr_match.sv
// destination address check against the addresses enabled for one port
`timescale 1ns/1ps
`default_nettype none
module ptpc_addr_match (
  input  wire logic [47:0]            dst,
  input  wire ptpc_pkg::ptpc_addr_en_t en,
  input  wire logic [47:0]            aux_addr,
  output logic                        hit
);
  always_comb begin
    hit = (en.pri  && dst == ptpc_pkg::PRI_ADDR)  ||
          (en.alt1 && dst == ptpc_pkg::ALT1_ADDR) ||
          (en.alt2 && dst == ptpc_pkg::ALT2_ADDR) ||
          (en.alt3 && dst == ptpc_pkg::ALT3_ADDR) ||
          (en.user && dst == aux_addr);
  end
endmodule : ptpc_addr_match
`default_nettype wire

// File: logic/ptpc_cap_hold.sv
// held clock, uuid and sequence id for one port and direction
`timescale 1ns/1ps
`default_nettype none
module ptpc_cap_hold (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                cap,
  input  wire logic                lock,
  input  wire logic                flag,
  input  wire ptpc_pkg::ptpc_cap_t din,
  output var  ptpc_pkg::ptpc_cap_t hold
);
  logic blocked;

  assign blocked = lock && flag;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hold <= '0;
    end else if (cap && !blocked) begin
      hold <= din;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  lock_hold_a: assert property (cap && lock && flag |=> $stable(hold))
    else $error("locked capture overwrote held values");
  free_load_a: assert property (cap && !(lock && flag) |=> hold == $past(din))
    else $error("unlocked capture did not load");
endmodule : ptpc_cap_hold
`default_nettype wire

// File: logic/ptpc_config_top.sv
// timestamp capture configuration register bank with axi4-lite slave
//
// Behaviour
// - port 2 master role: capture on sent sync and received delay request
// - port 2 slave role: capture on sent delay request, received sync; resets zero
// - port 1 role bit selects master or slave capture events; resets zero
// - primary enables accept address ...01:81 per port; both reset to one
// - first alternate enables accept ...01:82 per port; reset zero
// - second alternate enables accept ...01:83 per port; reset zero
// - third alternate enable accepts ...01:84 on port 2; reset zero
// - user enable accepts the programmed auxiliary address on port 2; reset zero
// - port 2 receive lock keeps held values while receive flag set; resets one
// - port 2 transmit lock keeps held values while transmit flag set; resets one
// - one 32-bit read/write configuration register at offset 194h
// - auxiliary address is 48 bits: 16 high bits, 32 low bits
`timescale 1ns/1ps
`default_nettype none
module ptpc_config_top (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [63:0]          ptp_clock,
  input  wire ptpc_pkg::ptpc_evt_t  port1_evt,
  input  wire ptpc_pkg::ptpc_evt_t  port2_evt,
  output var  ptpc_pkg::ptpc_cap_t  p1_rx_hold,
  output var  ptpc_pkg::ptpc_cap_t  p1_tx_hold,
  output var  ptpc_pkg::ptpc_cap_t  p2_rx_hold,
  output var  ptpc_pkg::ptpc_cap_t  p2_tx_hold,
  output logic [3:0]                cap_flags,
  output logic                      irq
);
  logic [11:0]             aw_addr_r;
  logic [31:0]             w_data_r;
  logic [3:0]              w_strb_r;
  logic                    wr_commit;
  logic                    wr_hit;
  logic [31:0]             cfg_r;
  logic [15:0]             aux_hi_r;
  logic [31:0]             aux_lo_r;
  logic [3:0]              irq_en_r;
  logic [3:0]              status_r;
  logic [3:0]              status_nxt;
  logic [3:0]              clr_pulse;
  logic [3:0]              cap_req;
  logic [3:0]              lock_vec;
  logic [47:0]             aux_addr;
  logic                    p1_hit;
  logic                    p2_hit;
  logic                    p1_master;
  logic                    p2_master;
  ptpc_pkg::ptpc_addr_en_t p1_en;
  ptpc_pkg::ptpc_addr_en_t p2_en;
  ptpc_pkg::ptpc_cap_t     cap_din [4];
  ptpc_pkg::ptpc_cap_t     hold_q  [4];
  logic [31:0]             rd_val;
  logic                    rd_ok;

  // ---------------- write channel ----------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      aw_addr_r     <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr_r     <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b1;
      w_data_r     <= '0;
      w_strb_r     <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data_r     <= s_axi_wdata;
      w_strb_r     <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // both halves held and no response outstanding: commit once
  assign wr_commit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_comb begin
    case (aw_addr_r)
      ptpc_pkg::AUX_HI_OFS,
      ptpc_pkg::AUX_LO_OFS,
      ptpc_pkg::CFG_OFS,
      ptpc_pkg::IRQ_STAT_OFS,
      ptpc_pkg::IRQ_CLR_OFS,
      ptpc_pkg::IRQ_EN_OFS:   wr_hit = 1'b1;
      default:                wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ptpc_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? ptpc_pkg::RESP_OKAY : ptpc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- registers ----------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_r <= ptpc_pkg::CFG_RESET;
    end else if (wr_commit && aw_addr_r == ptpc_pkg::CFG_OFS) begin
      cfg_r <= ptpc_pkg::apply_strb(cfg_r, w_data_r, w_strb_r) & ptpc_pkg::CFG_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aux_hi_r <= ptpc_pkg::AUX_HI_RESET;
      aux_lo_r <= ptpc_pkg::AUX_LO_RESET;
    end else if (wr_commit && aw_addr_r == ptpc_pkg::AUX_HI_OFS) begin
      aux_hi_r <= 16'(ptpc_pkg::apply_strb({16'h0000, aux_hi_r}, w_data_r, w_strb_r));
    end else if (wr_commit && aw_addr_r == ptpc_pkg::AUX_LO_OFS) begin
      aux_lo_r <= ptpc_pkg::apply_strb(aux_lo_r, w_data_r, w_strb_r);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_en_r <= ptpc_pkg::IRQ_EN_RESET;
    end else if (wr_commit && aw_addr_r == ptpc_pkg::IRQ_EN_OFS) begin
      irq_en_r <= 4'(ptpc_pkg::apply_strb({28'h0, irq_en_r}, w_data_r, w_strb_r));
    end
  end

  assign clr_pulse = (wr_commit && aw_addr_r == ptpc_pkg::IRQ_CLR_OFS && w_strb_r[0])
                     ? w_data_r[3:0] : 4'h0;

  assign aux_addr = {aux_hi_r, aux_lo_r};

  // ---------------- address enables and roles ----------------
  assign p2_master = cfg_r[ptpc_pkg::P2_ROLE_BIT];
  assign p1_master = cfg_r[ptpc_pkg::P1_ROLE_BIT];

  always_comb begin
    p2_en.pri  = cfg_r[ptpc_pkg::P2_PRI_BIT];
    p2_en.alt1 = cfg_r[ptpc_pkg::P2_ALT1_BIT];
    p2_en.alt2 = cfg_r[ptpc_pkg::P2_ALT2_BIT];
    p2_en.alt3 = cfg_r[ptpc_pkg::P2_ALT3_BIT];
    p2_en.user = cfg_r[ptpc_pkg::P2_USER_BIT];
    p1_en.pri  = cfg_r[ptpc_pkg::P1_PRI_BIT];
    p1_en.alt1 = cfg_r[ptpc_pkg::P1_ALT1_BIT];
    p1_en.alt2 = cfg_r[ptpc_pkg::P1_ALT2_BIT];
    // port 1 alternate 3 and user enables are outside this bank
    p1_en.alt3 = 1'b0;
    p1_en.user = 1'b0;
  end

  ptpc_addr_match u_p1_match (
    .dst      (port1_evt.dst),
    .en       (p1_en),
    .aux_addr (aux_addr),
    .hit      (p1_hit)
  );

  ptpc_addr_match u_p2_match (
    .dst      (port2_evt.dst),
    .en       (p2_en),
    .aux_addr (aux_addr),
    .hit      (p2_hit)
  );

  // ---------------- capture decision ----------------
  always_comb begin
    cap_req[ptpc_pkg::FL_P1_RX] = port1_evt.valid && !port1_evt.is_tx && p1_hit &&
                                  ptpc_pkg::capture_wanted(p1_master, port1_evt);
    cap_req[ptpc_pkg::FL_P1_TX] = port1_evt.valid && port1_evt.is_tx && p1_hit &&
                                  ptpc_pkg::capture_wanted(p1_master, port1_evt);
    cap_req[ptpc_pkg::FL_P2_RX] = port2_evt.valid && !port2_evt.is_tx && p2_hit &&
                                  ptpc_pkg::capture_wanted(p2_master, port2_evt);
    cap_req[ptpc_pkg::FL_P2_TX] = port2_evt.valid && port2_evt.is_tx && p2_hit &&
                                  ptpc_pkg::capture_wanted(p2_master, port2_evt);
  end

  always_comb begin
    lock_vec                     = 4'h0;
    lock_vec[ptpc_pkg::FL_P2_RX] = cfg_r[ptpc_pkg::P2_LKRX_BIT];
    lock_vec[ptpc_pkg::FL_P2_TX] = cfg_r[ptpc_pkg::P2_LKTX_BIT];
    cap_din[ptpc_pkg::FL_P1_RX]  = '{ptp_clock, port1_evt.uuid, port1_evt.seq};
    cap_din[ptpc_pkg::FL_P1_TX]  = '{ptp_clock, port1_evt.uuid, port1_evt.seq};
    cap_din[ptpc_pkg::FL_P2_RX]  = '{ptp_clock, port2_evt.uuid, port2_evt.seq};
    cap_din[ptpc_pkg::FL_P2_TX]  = '{ptp_clock, port2_evt.uuid, port2_evt.seq};
  end

  // a flag cleared in the same cycle no longer protects the held values
  for (genvar i = 0; i < 4; i++) begin : g_hold
    ptpc_cap_hold u_hold (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .cap     (cap_req[i]),
      .lock    (lock_vec[i]),
      .flag    (status_r[i] && !clr_pulse[i]),
      .din     (cap_din[i]),
      .hold    (hold_q[i])
    );
  end

  assign p1_rx_hold = hold_q[ptpc_pkg::FL_P1_RX];
  assign p1_tx_hold = hold_q[ptpc_pkg::FL_P1_TX];
  assign p2_rx_hold = hold_q[ptpc_pkg::FL_P2_RX];
  assign p2_tx_hold = hold_q[ptpc_pkg::FL_P2_TX];

  // ---------------- capture flags and interrupt ----------------
  // a new capture wins over a clear in the same cycle
  assign status_nxt = (status_r & ~clr_pulse) | cap_req;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_r <= 4'h0;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq       <= 1'b0;
      cap_flags <= 4'h0;
    end else begin
      irq       <= |(status_nxt & irq_en_r);
      cap_flags <= status_nxt;
    end
  end

  // ---------------- read channel ----------------
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      ptpc_pkg::AUX_HI_OFS:   rd_val = {16'h0000, aux_hi_r};
      ptpc_pkg::AUX_LO_OFS:   rd_val = aux_lo_r;
      ptpc_pkg::CFG_OFS:      rd_val = cfg_r;
      ptpc_pkg::IRQ_STAT_OFS: rd_val = {28'h0, status_r};
      ptpc_pkg::IRQ_CLR_OFS:  rd_val = 32'h0000_0000;
      ptpc_pkg::IRQ_EN_OFS:   rd_val = {28'h0, irq_en_r};
      default:                rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= ptpc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? ptpc_pkg::RESP_OKAY : ptpc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ---------------- checks ----------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence p2_evt_s(logic tx, logic sy, logic dq);
    port2_evt.valid && p2_hit && port2_evt.is_tx == tx &&
    port2_evt.is_sync == sy && port2_evt.is_dreq == dq;
  endsequence

  sequence cfg_write_s;
    wr_commit && aw_addr_r == ptpc_pkg::CFG_OFS && w_strb_r == 4'hf;
  endsequence

  p2_master_cap_a: assert property ((p2_master and p2_evt_s(1'b1, 1'b1, 1'b0))
                                    |=> status_r[ptpc_pkg::FL_P2_TX])
    else $error("master port 2 missed sync transmit capture");
  p2_slave_cap_a: assert property ((!p2_master and p2_evt_s(1'b0, 1'b1, 1'b0))
                                   ##1 !$past(status_r[ptpc_pkg::FL_P2_RX])
                                   |-> $rose(status_r[ptpc_pkg::FL_P2_RX]))
    else $error("slave port 2 missed sync receive capture");
  p1_role_sel_a: assert property (port1_evt.valid && port1_evt.is_tx && port1_evt.is_dreq &&
                                  !port1_evt.is_sync |->
                                  cap_req[ptpc_pkg::FL_P1_TX] == (!p1_master && p1_hit))
    else $error("port 1 role selects wrong transmit capture");
  reset_cfg_a: assert property ($past(!rst_n) |-> cfg_r == ptpc_pkg::CFG_RESET)
    else $error("configuration reset value wrong");
  alt1_match_a: assert property (p2_en.alt1 && port2_evt.dst == ptpc_pkg::ALT1_ADDR
                                 |-> p2_hit)
    else $error("alternate address 1 not matched");
  alt2_match_a: assert property (p1_en.alt2 && port1_evt.dst == ptpc_pkg::ALT2_ADDR
                                 |-> p1_hit)
    else $error("alternate address 2 not matched");
  alt3_off_a: assert property (!p2_en.alt3 && !p2_en.user &&
                               port2_evt.dst == ptpc_pkg::ALT3_ADDR |-> !p2_hit)
    else $error("disabled alternate address 3 matched");
  alt3_match_a: assert property (p2_en.alt3 && port2_evt.dst == ptpc_pkg::ALT3_ADDR
                                 |-> p2_hit)
    else $error("alternate address 3 not matched");
  aux_user_a: assert property (p2_en.user && port2_evt.dst == {aux_hi_r, aux_lo_r}
                               |-> p2_hit)
    else $error("auxiliary address not matched");
  p2_rx_lock_a: assert property (cap_req[ptpc_pkg::FL_P2_RX] && lock_vec[ptpc_pkg::FL_P2_RX] &&
                                 status_r[ptpc_pkg::FL_P2_RX] && !clr_pulse[ptpc_pkg::FL_P2_RX]
                                 |=> $stable(p2_rx_hold))
    else $error("locked port 2 receive capture overwrote held values");
  p2_tx_lock_a: assert property (cap_req[ptpc_pkg::FL_P2_TX] && lock_vec[ptpc_pkg::FL_P2_TX] &&
                                 status_r[ptpc_pkg::FL_P2_TX] && !clr_pulse[ptpc_pkg::FL_P2_TX]
                                 |=> $stable(p2_tx_hold))
    else $error("locked port 2 transmit capture overwrote held values");
  cfg_write_a: assert property (cfg_write_s |=>
                                cfg_r == ($past(w_data_r) & ptpc_pkg::CFG_MASK) && s_axi_bvalid)
    else $error("configuration write not stored");
  aux_split_a: assert property (wr_commit && aw_addr_r == ptpc_pkg::AUX_HI_OFS &&
                                w_strb_r == 4'hf |=> aux_addr[47:32] == $past(w_data_r[15:0]))
    else $error("auxiliary high half not stored");
  ptp_only_a: assert property (|cap_req[3:2] |-> p2_hit)
    else $error("capture without enabled address");
endmodule : ptpc_config_top
`default_nettype wire

// File: test/ptpc_port_model.sv
// far-side model of the two port frame paths: one-cycle frame event pulses
`timescale 1ns/1ps
`default_nettype none
module ptpc_port_model (
  input  wire logic                ref_clk,
  input  wire logic                send,
  input  wire logic                to_p2,
  input  wire ptpc_pkg::ptpc_evt_t evt_in,
  output var  ptpc_pkg::ptpc_evt_t port1_evt,
  output var  ptpc_pkg::ptpc_evt_t port2_evt
);
  localparam int unsigned EW = $bits(ptpc_pkg::ptpc_evt_t);

  // between frames the payload toggles every cycle so stale fields never look valid
  always_ff @(posedge ref_clk) begin
    port1_evt <= (send && !to_p2) ? evt_in : {1'b0, ~port1_evt[EW-2:0]};
    port2_evt <= (send && to_p2) ? evt_in : {1'b0, ~port2_evt[EW-2:0]};
  end
endmodule : ptpc_port_model
`default_nettype wire

// File: test/test_ptp_capture_port_config.sv
// self-checking bench for the capture configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module test_ptp_capture_port_config;
  logic                ref_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic [11:0]         s_axi_awaddr = 12'h000;
  logic                s_axi_awvalid = 1'b0;
  logic                s_axi_awready;
  logic [31:0]         s_axi_wdata = 32'h0;
  logic [3:0]          s_axi_wstrb = 4'h0;
  logic                s_axi_wvalid = 1'b0;
  logic                s_axi_wready;
  logic [1:0]          s_axi_bresp;
  logic                s_axi_bvalid;
  logic                s_axi_bready = 1'b0;
  logic [11:0]         s_axi_araddr = 12'h000;
  logic                s_axi_arvalid = 1'b0;
  logic                s_axi_arready;
  logic [31:0]         s_axi_rdata;
  logic [1:0]          s_axi_rresp;
  logic                s_axi_rvalid;
  logic                s_axi_rready = 1'b0;
  logic [63:0]         ptp_clock = 64'h0;
  ptpc_pkg::ptpc_evt_t evt_in = '0;
  ptpc_pkg::ptpc_evt_t port1_evt;
  ptpc_pkg::ptpc_evt_t port2_evt;
  ptpc_pkg::ptpc_cap_t p1_rx_hold;
  ptpc_pkg::ptpc_cap_t p1_tx_hold;
  ptpc_pkg::ptpc_cap_t p2_rx_hold;
  ptpc_pkg::ptpc_cap_t p2_tx_hold;
  logic [3:0]          cap_flags;
  logic                irq;
  logic                send = 1'b0;
  logic                to_p2 = 1'b0;
  int                  fails = 0;
  int                  compares = 0;
  logic [31:0]         seed = 32'h62c3;
  logic [31:0]         cfg;
  logic [31:0]         rd;
  logic [1:0]          resp;
  logic [15:0]         aux_hi;
  logic [31:0]         aux_lo;
  logic [3:0]          irq_en;
  logic [47:0]         dst;
  logic [1:0]          idx;
  logic [127:0]        held;
  bit                  exp;

  ptpc_config_top ptpc_config_top_i (
    .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ptp_clock, .port1_evt, .port2_evt, .p1_rx_hold,
    .p1_tx_hold, .p2_rx_hold, .p2_tx_hold, .cap_flags, .irq
  );
  ptpc_port_model ptpc_port_model_i (
    .ref_clk, .send, .to_p2, .evt_in, .port1_evt, .port2_evt
  );

  always #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    rnd = seed;
  endfunction : rnd

  function automatic bit exp_cap(input bit p2, input logic [31:0] c, input bit tx,
                                 input bit sy, input bit dq, input logic [47:0] d);
    bit m;
    bit hit;
    m = p2 ? c[31] : c[23];
    hit = (d == 48'h0100_5e00_0181 && c[p2 ? 30 : 22]) ||
          (d == 48'h0100_5e00_0182 && c[p2 ? 29 : 21]) ||
          (d == 48'h0100_5e00_0183 && c[p2 ? 28 : 20]) ||
          (p2 && ((d == 48'h0100_5e00_0184 && c[27]) || (d == {aux_hi, aux_lo} && c[26])));
    exp_cap = hit && (m ? ((tx && sy) || (!tx && dq)) : ((tx && dq) || (!tx && sy)));
  endfunction : exp_cap

  function automatic logic [127:0] pick(input logic [1:0] ix);
    case (ix)
      2'd0: pick = p1_rx_hold;
      2'd1: pick = p1_tx_hold;
      2'd2: pick = p2_rx_hold;
      default: pick = p2_tx_hold;
    endcase
  endfunction : pick

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    fails++;
    final_report();
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    fails++;
    final_report();
  endtask : axi_rd

  // event leaves the model one edge after send and is taken at the edge after that
  task automatic fire(input bit p2, input bit tx, input bit sy, input bit dq);
    @(posedge ref_clk);
    ptp_clock <= {rnd(), rnd()};
    to_p2 <= p2;
    evt_in <= {1'b1, tx, sy, dq, dst, rnd(), rnd()};
    send <= 1'b1;
    @(posedge ref_clk);
    send <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : fire

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    axi_rd(ptpc_pkg::CFG_OFS);
    `CHK("cfg reset", 32'h4340_0000, rd)
    `CHK("flags reset", 4'h0, cap_flags)
    axi_rd(ptpc_pkg::AUX_LO_OFS);
    `CHK("aux lo reset", 32'h0, rd)
    axi_rd(12'h0f0);
    `CHK("unmapped rd", 34'h2_0000_0000, {resp, rd})
    axi_wr(12'h0f0, rnd(), 4'hf);
    `CHK("unmapped wr", ptpc_pkg::RESP_SLVERR, resp)
    axi_wr(ptpc_pkg::CFG_OFS, 32'h0, 4'h8);
    axi_rd(ptpc_pkg::CFG_OFS);
    `CHK("cfg lane", 32'h0040_0000, rd)
    rd = rnd();
    aux_hi = rd[15:0];
    axi_wr(ptpc_pkg::AUX_HI_OFS, rd, 4'hf);
    aux_lo = rnd();
    axi_wr(ptpc_pkg::AUX_LO_OFS, aux_lo, 4'hf);
    axi_rd(ptpc_pkg::AUX_HI_OFS);
    `CHK("aux hi", {16'h0, aux_hi}, rd)
    axi_rd(ptpc_pkg::AUX_LO_OFS);
    `CHK("aux lo", aux_lo, rd)
    for (int i = 0; i < 96; i++) begin
      cfg = rnd() & 32'hfff0_0000;
      cfg[31] = i[0];
      cfg[23] = i[0];
      case (rnd() % 6)
        0: dst = 48'h0100_5e00_0181;
        1: dst = 48'h0100_5e00_0182;
        2: dst = 48'h0100_5e00_0183;
        3: dst = 48'h0100_5e00_0184;
        4: dst = {aux_hi, aux_lo};
        default: dst = 48'({rnd(), rnd()});
      endcase
      axi_wr(ptpc_pkg::CFG_OFS, cfg, 4'hf);
      `CHK("cfg wr resp", ptpc_pkg::RESP_OKAY, resp)
      axi_rd(ptpc_pkg::CFG_OFS);
      `CHK("cfg rdback", cfg, rd)
      irq_en = 4'(rnd());
      axi_wr(ptpc_pkg::IRQ_EN_OFS, {28'h0, irq_en}, 4'hf);
      axi_wr(ptpc_pkg::IRQ_CLR_OFS, 32'hf, 4'hf);
      fire(i[4], i[1], i[2], i[3]);
      exp = exp_cap(i[4], cfg, i[1], i[2], i[3], dst);
      idx = {i[4], i[1]};
      `CHK("flags", {3'b0, exp} << idx, cap_flags)
      `CHK("irq", exp && irq_en[idx], irq)
      if (exp) `CHK("hold", {ptp_clock, evt_in.uuid, evt_in.seq}, pick(idx))
    end
    dst = 48'h0100_5e00_0181;
    for (int k = 0; k < 4; k++) begin
      idx = {1'b1, k[0]};
      axi_wr(ptpc_pkg::CFG_OFS, k[1] ? 32'hc300_0000 : 32'hc000_0000, 4'hf);
      axi_wr(ptpc_pkg::IRQ_CLR_OFS, 32'hf, 4'hf);
      fire(1'b1, k[0], k[0], !k[0]);
      held = pick(idx);
      fire(1'b1, k[0], k[0], !k[0]);
      if (!k[1]) held = {ptp_clock, evt_in.uuid, evt_in.seq};
      `CHK("lock hold", held, pick(idx))
      axi_rd(ptpc_pkg::IRQ_STAT_OFS);
      `CHK("status", 32'h4 << k[0], rd)
      axi_wr(ptpc_pkg::IRQ_CLR_OFS, 32'hf, 4'hf);
      fire(1'b1, k[0], k[0], !k[0]);
      `CHK("after clear", {ptp_clock, evt_in.uuid, evt_in.seq}, pick(idx))
    end
    final_report();
  end
endmodule : test_ptp_capture_port_config
`default_nettype wire
